// ### logic/monitor_mode_entry.sv
// Monitor mode entry: latches the mode at reset release, then, in either monitor
// mode, runs the security handshake and ready break on the single wired-OR line.
// Assumes sys_clk_i is the bus clock and all inputs are synchronous.
`default_nettype none
`include "monitor_entry_consts.svh"

module monitor_mode_entry
   import monitor_entry_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        irq_test_voltage_i,
   input  wire logic        rst_test_voltage_i,
   input  wire logic [7:0]  reset_vector_high_i,
   input  wire logic [7:0]  reset_vector_low_i,
   input  wire logic        mode_select_a_i,
   input  wire logic        mode_select_b_i,
   input  wire logic        mode_select_c_i,
   input  wire logic        clock_divisor_select_i,
   input  wire logic        host_serial_line_i,
   input  wire logic [15:0] fetch_addr_i,
   output logic             host_serial_line_o,
   output logic             host_serial_line_oe_o,
   output logic             mode_latched_o,
   output logic             monitor_mode_o,
   output logic             forced_monitor_o,
   output logic             bus_div4_o,
   output logic             pll_force_off_o,
   output logic             watchdog_enable_o,
   output logic [7:0]       security_byte_o,
   output logic             security_valid_o,
   output logic             command_ready_o,
   output logic             monitor_rom_select_o
);

   entry_mode_t mode;
   seq_state_t  seq;
   logic [3:0]  sec_count;
   logic        break_start;
   logic [7:0]  rx_byte;
   logic        rx_valid;
   logic        line_pull;
   logic        break_done;
   logic        rx_enable;
   logic        blank_vector;
   entry_mode_t next_mode;

   function automatic logic in_rom(input logic [15:0] addr);
      in_rom = (addr >= `ROM_FIRST) && (addr <= `ROM_LAST);
   endfunction

   // ----------------------------------------
   // Entry decode
   // ----------------------------------------
   always_comb begin
      blank_vector = (reset_vector_high_i == `ERASED_BYTE) &&
                     (reset_vector_low_i == `ERASED_BYTE);
      if (irq_test_voltage_i &&
          ({mode_select_a_i, mode_select_b_i, mode_select_c_i} == `SEL_NORMAL)) begin
         next_mode = MODE_NORMAL;
      end else if (blank_vector && !irq_test_voltage_i) begin
         next_mode = MODE_FORCED;
      end else begin
         // Test voltage with wrong select pins falls back to user
         next_mode = MODE_USER;
      end
   end

   // ----------------------------------------
   // Mode latch at first edge after release
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         mode_latched_o <= 1'b0;
         mode           <= MODE_USER;
         bus_div4_o     <= 1'b0;
      end else if (!mode_latched_o) begin
         mode_latched_o <= 1'b1;
         mode           <= next_mode;
         // Forced entry ignores the divisor pin and runs at quarter rate
         bus_div4_o     <= (next_mode == MODE_FORCED) ? 1'b1 : clock_divisor_select_i;
      end
   end

   // ----------------------------------------
   // Clock loop and watchdog control
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         monitor_mode_o    <= 1'b0;
         forced_monitor_o  <= 1'b0;
         pll_force_off_o   <= 1'b0;
         watchdog_enable_o <= 1'b0;
      end else begin
         monitor_mode_o   <= mode_latched_o && (mode != MODE_USER);
         forced_monitor_o <= mode_latched_o && (mode == MODE_FORCED);
         pll_force_off_o  <= mode_latched_o && (mode != MODE_USER);
         case (mode)
            MODE_NORMAL: watchdog_enable_o <= !(irq_test_voltage_i || rst_test_voltage_i);
            MODE_FORCED: watchdog_enable_o <= 1'b0;
            default:     watchdog_enable_o <= mode_latched_o;
         endcase
      end
   end

   // ----------------------------------------
   // Security wait and ready break
   // ----------------------------------------
   assign rx_enable = (seq == SEQ_SECURITY) && !line_pull;

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         seq              <= SEQ_OFF;
         sec_count        <= '0;
         break_start      <= 1'b0;
         security_byte_o  <= '0;
         security_valid_o <= 1'b0;
         command_ready_o  <= 1'b0;
      end else begin
         break_start      <= 1'b0;
         security_valid_o <= 1'b0;
         case (seq)
            SEQ_OFF: begin
               if (mode_latched_o && (mode != MODE_USER)) begin
                  seq <= SEQ_SECURITY;
               end
            end
            SEQ_SECURITY: begin
               if (rx_valid) begin
                  security_byte_o  <= rx_byte;
                  security_valid_o <= 1'b1;
                  sec_count        <= sec_count + 4'h1;
                  if (sec_count == `SECURITY_LAST) begin
                     seq         <= SEQ_BREAK;
                     break_start <= 1'b1;
                  end
               end
            end
            SEQ_BREAK: begin
               if (break_done) begin
                  seq             <= SEQ_READY;
                  command_ready_o <= 1'b1;
               end
            end
            SEQ_READY: command_ready_o <= 1'b1;
            default:   seq <= SEQ_OFF;
         endcase
      end
   end

   // ----------------------------------------
   // Firmware region and pin drive
   // ----------------------------------------
   // Only the firmware window is flagged; every other address stays
   // reachable so downloaded RAM code can run.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         monitor_rom_select_o <= 1'b0;
         host_serial_line_o   <= 1'b0;
      end else begin
         monitor_rom_select_o <= monitor_mode_o && in_rom(fetch_addr_i);
         host_serial_line_o   <= 1'b0;
      end
   end

   assign host_serial_line_oe_o = line_pull;

   nrz_bit_engine u_engine (
      .sys_clk_i     (sys_clk_i),
      .rstn_i        (rstn_i),
      .line_i        (host_serial_line_i),
      .rx_enable_i   (rx_enable),
      .break_start_i (break_start),
      .rx_byte_o     (rx_byte),
      .rx_valid_o    (rx_valid),
      .line_pull_o   (line_pull),
      .break_done_o  (break_done)
   );

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Counts pulled cycles so the whole break length is checked, not a prefix
   logic [11:0] oe_run;

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         oe_run <= '0;
      end else if (host_serial_line_oe_o) begin
         oe_run <= oe_run + 12'h001;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   mode_held_a: assert property (mode_latched_o |=> $stable(mode))
      else $error("mode changed after latch");
   forced_entry_a: assert property ($rose(mode_latched_o) && $past(blank_vector) &&
                                    !$past(irq_test_voltage_i) |-> mode == MODE_FORCED)
      else $error("blank vector did not force monitor");
   forced_wdog_a: assert property (mode == MODE_FORCED |=> !watchdog_enable_o)
      else $error("watchdog on in forced monitor");
   normal_wdog_a: assert property (mode == MODE_NORMAL && (irq_test_voltage_i || rst_test_voltage_i)
                                   |=> !watchdog_enable_o)
      else $error("watchdog on under test voltage");
   pll_off_a: assert property (mode_latched_o && mode != MODE_USER |=> pll_force_off_o)
      else $error("loop not forced off in monitor");
   break_after_sec_a: assert property (seq == SEQ_SECURITY && rx_valid && sec_count == `SECURITY_LAST
                                       |-> ##2 host_serial_line_oe_o)
      else $error("break not started after eighth byte");
   break_length_a: assert property ($fell(host_serial_line_oe_o) |-> oe_run == `BREAK_CYCLES)
      else $error("break length wrong");
   ready_after_break_a: assert property ($fell(host_serial_line_oe_o) |-> ##1 command_ready_o)
      else $error("ready not raised after break");
   drive_low_a: assert property (!host_serial_line_o)
      else $error("line driven high");
   rom_select_a: assert property (monitor_rom_select_o |-> $past(fetch_addr_i) >= `ROM_FIRST &&
                                  $past(fetch_addr_i) <= `ROM_LAST)
      else $error("rom select outside firmware region");

   normal_entry_c: cover property ($rose(monitor_mode_o) && !forced_monitor_o);
   forced_entry_c: cover property ($rose(forced_monitor_o));
   security_done_c: cover property (seq == SEQ_SECURITY ##1 seq == SEQ_BREAK);
   ready_c: cover property ($rose(command_ready_o));

endmodule

`default_nettype wire

// ### logic/monitor_entry_consts.svh
// Constants for the monitor mode entry block.
// Assumes the system clock is also the internal bus clock.
`ifndef MONITOR_ENTRY_CONSTS_SVH
`define MONITOR_ENTRY_CONSTS_SVH

// ----------------------------------------
// Serial timing
// ----------------------------------------
`define BIT_CYCLES     9'h116
`define HALF_BIT       9'h08B
`define BREAK_BITS     12'h00A
`define BREAK_CYCLES   (`BREAK_BITS * 12'(`BIT_CYCLES))
`define LAST_DATA_BIT  3'h7

// ----------------------------------------
// Entry conditions
// ----------------------------------------
`define ERASED_BYTE    8'hFF
`define SEL_NORMAL     3'h2
`define SECURITY_LAST  4'h7

// ----------------------------------------
// Monitor firmware region
// ----------------------------------------
`define ROM_FIRST      16'hFE20
`define ROM_LAST       16'hFF7D

`endif

// ### logic/monitor_entry_pkg.sv
// Types shared by the monitor mode entry block.
// Assumes nothing of its surroundings.
`default_nettype none

package monitor_entry_pkg;

   typedef enum logic [1:0] {
      MODE_USER   = 2'b00,
      MODE_NORMAL = 2'b01,
      MODE_FORCED = 2'b10
   } entry_mode_t;

   typedef enum logic [1:0] {
      SEQ_OFF      = 2'b00,
      SEQ_SECURITY = 2'b01,
      SEQ_BREAK    = 2'b10,
      SEQ_READY    = 2'b11
   } seq_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_t;

endpackage

`default_nettype wire

// ### logic/nrz_bit_engine.sv
// NRZ character receiver and break transmitter on the wired-OR line.
// Assumes the line input is synchronous and the line is pulled up outside.
`default_nettype none
`include "monitor_entry_consts.svh"

module nrz_bit_engine
   import monitor_entry_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       line_i,
   input  wire logic       rx_enable_i,
   input  wire logic       break_start_i,
   output logic [7:0]      rx_byte_o,
   output logic            rx_valid_o,
   output logic            line_pull_o,
   output logic            break_done_o
);

   rx_state_t   rx_state;
   logic [8:0]  rx_cnt;
   logic [2:0]  rx_bit;
   logic [7:0]  rx_shift;
   logic        line_prev;
   logic [11:0] tx_cnt;

   // ----------------------------------------
   // Receiver, start bit, 8 data LSB first, stop
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         rx_state  <= RX_IDLE;
         rx_cnt    <= '0;
         rx_bit    <= '0;
         rx_shift  <= '0;
         rx_byte_o <= '0;
         rx_valid_o <= 1'b0;
         line_prev <= 1'b1;
      end else begin
         rx_valid_o <= 1'b0;
         line_prev  <= line_i;
         case (rx_state)
            RX_IDLE: begin
               // Falling edge only, so a held-low line never restarts a frame
               if (rx_enable_i && line_prev && !line_i) begin
                  rx_state <= RX_START;
                  rx_cnt   <= `HALF_BIT;
               end
            end
            RX_START: begin
               if (rx_cnt == '0) begin
                  rx_state <= line_i ? RX_IDLE : RX_DATA;
                  rx_cnt   <= `BIT_CYCLES - 9'h001;
                  rx_bit   <= '0;
               end else begin
                  rx_cnt <= rx_cnt - 9'h001;
               end
            end
            RX_DATA: begin
               if (rx_cnt == '0) begin
                  rx_shift <= {line_i, rx_shift[7:1]};
                  rx_cnt   <= `BIT_CYCLES - 9'h001;
                  rx_bit   <= rx_bit + 3'h1;
                  if (rx_bit == `LAST_DATA_BIT) begin
                     rx_state <= RX_STOP;
                  end
               end else begin
                  rx_cnt <= rx_cnt - 9'h001;
               end
            end
            RX_STOP: begin
               if (rx_cnt == '0) begin
                  // Framing errors are dropped silently
                  if (line_i) begin
                     rx_byte_o  <= rx_shift;
                     rx_valid_o <= 1'b1;
                  end
                  rx_state <= RX_IDLE;
               end else begin
                  rx_cnt <= rx_cnt - 9'h001;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Break transmitter, pull low then release
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         line_pull_o  <= 1'b0;
         tx_cnt       <= '0;
         break_done_o <= 1'b0;
      end else begin
         break_done_o <= 1'b0;
         if (break_start_i && !line_pull_o) begin
            line_pull_o <= 1'b1;
            tx_cnt      <= `BREAK_CYCLES - 12'h001;
         end else if (line_pull_o) begin
            if (tx_cnt == '0) begin
               line_pull_o  <= 1'b0;
               break_done_o <= 1'b1;
            end else begin
               tx_cnt <= tx_cnt - 12'h001;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ### tb/host_link_model.sv
// Host side of the single-wire monitor link: sends NRZ characters by pulling the line low.
// Assumes an outside pull-up; the device's own pull arrives on dev_pull_i.
`default_nettype none

module host_link_model (
   input  wire logic sys_clk_i,
   input  wire logic dev_pull_i,
   output logic      line_o
);
   timeunit 1ns;
   timeprecision 1ns;

   localparam int BIT = 278;

   logic host_pull = 1'b0;

   // Nobody drives high: a released line floats up to the pull-up level
   assign line_o = ~(host_pull | dev_pull_i);

   // ----------------------------------------
   // Character sender
   // ----------------------------------------
   // Gap sets how slow the host is between characters; stop_ok low forces a framing error
   task automatic send_byte(input logic [7:0] b, input logic stop_ok, input int gap);
      logic [9:0] frame;
      frame = {stop_ok, b, 1'b0};
      repeat (gap) @(posedge sys_clk_i);
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk_i) host_pull <= ~frame[i];
         repeat (BIT - 1) @(posedge sys_clk_i);
      end
      @(posedge sys_clk_i) host_pull <= 1'b0;
   endtask
endmodule

`default_nettype wire

// ### tb/monitor_mode_entry_tb.sv
// Self-checking bench for the monitor mode entry block.
// Assumes the host model owns the line; inputs change on rising edges.
`default_nettype none

module monitor_mode_entry_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic        sys_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        irq_tv = 1'b0;
   logic        rst_tv = 1'b0;
   logic        div_sel = 1'b0;
   logic [7:0]  vec_hi = 8'hFF;
   logic [7:0]  vec_lo = 8'hFF;
   logic [2:0]  sel = 3'h0;
   logic [15:0] fetch_addr = 16'h0000;
   logic        line, line_out, line_oe, latched, mmode, forced, div4, pll_off, wd_en;
   logic        sec_valid, cmd_ready, rom_sel;
   logic [7:0]  sec_byte;
   logic [7:0]  rx_q[$];
   int          n_fail = 0, total_checks = 0, cycles = 0;
   int          brk_len = 0, low_len = 0, oe_last = 0, rdy_at = 0;

   always #25 sys_clk_i = ~sys_clk_i;

   monitor_mode_entry u_dut (
      .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .irq_test_voltage_i(irq_tv), .rst_test_voltage_i(rst_tv),
      .reset_vector_high_i(vec_hi), .reset_vector_low_i(vec_lo), .mode_select_a_i(sel[2]),
      .mode_select_b_i(sel[1]), .mode_select_c_i(sel[0]), .clock_divisor_select_i(div_sel),
      .host_serial_line_i(line), .fetch_addr_i(fetch_addr), .host_serial_line_o(line_out),
      .host_serial_line_oe_o(line_oe), .mode_latched_o(latched), .monitor_mode_o(mmode), .forced_monitor_o(forced),
      .bus_div4_o(div4), .pll_force_off_o(pll_off), .watchdog_enable_o(wd_en), .security_byte_o(sec_byte),
      .security_valid_o(sec_valid), .command_ready_o(cmd_ready), .monitor_rom_select_o(rom_sel));

   host_link_model u_host (.sys_clk_i(sys_clk_i), .dev_pull_i(line_oe & ~line_out), .line_o(line));

   // ----------------------------------------
   // Observers and hang guard
   // ----------------------------------------
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (rstn_i && sec_valid === 1'b1)
         rx_q.push_back(sec_byte);
      if (line_oe === 1'b1) begin
         brk_len <= brk_len + 1;
         oe_last <= cycles;
      end
      if (line_oe === 1'b1 && line === 1'b0)
         low_len <= low_len + 1;
      if (cmd_ready === 1'b1 && rdy_at == 0)
         rdy_at <= cycles;
      if (cycles == 50000) begin
         n_fail++;
         $display("[FAIL] %0t timeout", $time);
         wrap_up();
      end
   end

   // ----------------------------------------
   // Compare and access tasks
   // ----------------------------------------
   task automatic chk_bit(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Reset, release, then scramble the pins right after the latching edge
   task automatic enter(input logic irq, input logic [15:0] vec, input logic [2:0] s, input logic dv);
      @(posedge sys_clk_i);
      rstn_i <= 1'b0;
      irq_tv <= irq;
      rst_tv <= 1'b0;
      {vec_hi, vec_lo} <= vec;
      sel <= s;
      div_sel <= dv;
      repeat (8) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      @(posedge sys_clk_i);
      {vec_hi, vec_lo} <= ~vec;
      sel <= ~s;
      div_sel <= ~dv;
      repeat (3) @(posedge sys_clk_i);
      #1;
   endtask

   task automatic mode_case(input logic irq, input logic [15:0] vec, input logic [2:0] s, input logic dv,
                            input logic e_mon, input logic e_frc, input logic e_d4);
      enter(irq, vec, s, dv);
      chk_bit(latched, 1'b1, "latched");
      chk_bit(mmode, e_mon, "monitor");
      chk_bit(forced, e_frc, "forced");
      chk_bit(pll_off, e_mon, "pll off");
      chk_bit(wd_en, ~e_mon, "watchdog");
      chk_bit(div4, e_d4, "div4");
   endtask

   task automatic tv_chk(input logic i, input logic r, input logic exp);
      @(posedge sys_clk_i);
      irq_tv <= i;
      rst_tv <= r;
      repeat (3) @(posedge sys_clk_i);
      #1 chk_bit(wd_en, exp, "watchdog tracking");
   endtask

   task automatic rom_chk(input logic [15:0] a, input logic exp);
      @(posedge sys_clk_i) fetch_addr <= a;
      repeat (2) @(posedge sys_clk_i);
      #1 chk_bit(rom_sel, exp, "rom select");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int n;
      mode_case(1'b1, 16'h1234, 3'h2, 1'b0, 1'b1, 1'b0, 1'b0);
      mode_case(1'b1, 16'h1234, 3'h2, 1'b1, 1'b1, 1'b0, 1'b1);
      mode_case(1'b1, 16'hFFFF, 3'h2, 1'b0, 1'b1, 1'b0, 1'b0);
      mode_case(1'b0, 16'hFFFF, 3'h5, 1'b0, 1'b1, 1'b1, 1'b1);
      mode_case(1'b0, 16'hFF00, 3'h2, 1'b0, 1'b0, 1'b0, 1'b0);
      mode_case(1'b0, 16'h00FF, 3'h2, 1'b1, 1'b0, 1'b0, 1'b1);
      mode_case(1'b1, 16'h1234, 3'h3, 1'b1, 1'b0, 1'b0, 1'b1);
      rom_chk(16'hFE20, 1'b0);
      enter(1'b1, 16'h1234, 3'h2, 1'b0);
      tv_chk(1'b0, 1'b1, 1'b0);
      tv_chk(1'b0, 1'b0, 1'b1);
      tv_chk(1'b1, 1'b0, 1'b0);
      enter(1'b0, 16'hFFFF, 3'h0, 1'b0);
      tv_chk(1'b1, 1'b1, 1'b0);
      tv_chk(1'b0, 1'b0, 1'b0);
      rom_chk(16'hFE1F, 1'b0);
      rom_chk(16'hFE20, 1'b1);
      rom_chk(16'hFF7D, 1'b1);
      rom_chk(16'hFF7E, 1'b0);
      // Framing error first: it must neither pulse nor count toward the eight
      rx_q.delete();
      u_host.send_byte(8'hA5, 1'b0, 20);
      for (int i = 0; i < 8; i++) begin
         if (i == 7)
            #1 chk_bit(line_oe, 1'b0, "no early break");
         u_host.send_byte(8'(8'h11 * i + 8'h3C), 1'b1, 20 + 300 * (i % 2));
      end
      n = 0;
      while (cmd_ready !== 1'b1 && n < 4000) begin
         @(posedge sys_clk_i);
         n++;
      end
      #1 chk_bit(cmd_ready, 1'b1, "command ready");
      chk_val(16'(rx_q.size()), 16'h0008, "security count");
      for (int i = 0; i < 8 && i < rx_q.size(); i++)
         chk_val(16'(rx_q[i]), 16'(8'(8'h11 * i + 8'h3C)), "security byte");
      chk_val(16'(brk_len), 16'(10 * 278), "break length");
      chk_val(16'(low_len), 16'(10 * 278), "line low in break");
      chk_val(16'(rdy_at - oe_last), 16'h0002, "ready after break");
      u_host.send_byte(8'h5A, 1'b1, 40);
      repeat (300) @(posedge sys_clk_i);
      #1 chk_val(16'(rx_q.size()), 16'h0008, "no reception after break");
      chk_val(16'(brk_len), 16'(10 * 278), "no second break");
      wrap_up();
   end
endmodule

`default_nettype wire
